// file: hdl/lmc_regs.vh
`ifndef LMC_REGS_VH
`define LMC_REGS_VH
// mode state codes, one-hot
`define LMC_ST_POR 5'h01
`define LMC_ST_READY 5'h02
`define LMC_ST_OPER 5'h04
`define LMC_ST_PDOWN 5'h08
`define LMC_ST_TXOFF 5'h10
// clock rate and timing figures
`define LMC_CLK_HZ 20000000
`define LMC_WAKE_US 10
`define LMC_REG_SETTLE_US 1200
`define LMC_MISMATCH_US 4
// cycle counts of the times above at the 20 MHz clock
`define LMC_WAKE_CYC 16'h00c8
`define LMC_SETTLE_CYC 16'h5dc0
`define LMC_MISMATCH_CYC 16'h0050
`define LMC_CNT_W 16
`endif

// file: hdl/lmc_mode_control.v
// Notes on behaviour
// - hold logic in reset until battery rises above the on-threshold, then leave
// - battery below off-threshold returns to power-on reset from any state
// - power-down: driver and regulator off, only wake and receiver detection active
// - wake in power-down goes to ready, regulator on, then operation when stable
// - power-down is reached only from operation or transmitter-off
// - ready: regulator on, driver off, bus recessive
// - ready waits for regulator ok and chip select high, then operation
// - leaving reset samples chip select: low gives ready, high operation
// - operation: regulator and driver on, wake detection off; chip select falling edge enters power-down
// - operation: fault pin low enters transmitter-off
// - driver off whenever fault pin is low, from any source
// - driver back on when pin high, unless internal fault persists
// - transmitter-off: pin high to operation, chip select low to power-down
// - driver off while regulator reported unstable
// - bus activity flagged only after bus low for the full wake time
// - thermal overload shuts off driver and regulator
// - regulator switched off when its output falls below turn-off level
// - enabled driver makes bus dominant on transmit low, recessive on high
// - receive data follows sensed bus level
// - debounced transmit/bus mismatch pulls fault pin low
`timescale 1ns/10ps
`include "lmc_regs.vh"
module lmc_mode_control #(
    parameter CNT_W = `LMC_CNT_W,
    parameter [CNT_W-1:0] WAKE_CYC = `LMC_WAKE_CYC,
    parameter [CNT_W-1:0] SETTLE_CYC = `LMC_SETTLE_CYC,
    parameter [CNT_W-1:0] MISMATCH_CYC = `LMC_MISMATCH_CYC
) (
    // clock and reset
    input wire clk,
    input wire reset,
    // analog comparator results
    input wire battery_on,
    input wire battery_off,
    input wire regulator_ok,
    input wire regulator_low,
    input wire thermal_overload,
    input wire bus_line_low,
    // host pins
    input wire tx_data,
    input wire chip_select_wake,
    input wire fault_tx_enable_pin_in,
    output reg fault_tx_enable_pin_out,
    output reg fault_tx_enable_pin_oe_n,
    output reg rx_data,
    // bus driver and regulator controls
    output reg bus_line_drive_low,
    output reg driver_enable,
    output reg regulator_enable,
    output reg wake_detect_enable,
    output reg [4:0] mode
);
    localparam [4:0] ST_POR = `LMC_ST_POR;
    localparam [4:0] ST_READY = `LMC_ST_READY;
    localparam [4:0] ST_OPER = `LMC_ST_OPER;
    localparam [4:0] ST_PDOWN = `LMC_ST_PDOWN;
    localparam [4:0] ST_TXOFF = `LMC_ST_TXOFF;

    // two-stage synchronisers for all asynchronous inputs
    localparam NSYNC = 9;
    wire [NSYNC-1:0] async_in;
    reg [NSYNC-1:0] sync_a;
    reg [NSYNC-1:0] sync_b;
    assign async_in = {battery_on, battery_off, regulator_ok, regulator_low,
                       thermal_overload, bus_line_low, tx_data, chip_select_wake,
                       fault_tx_enable_pin_in};
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
            always @(posedge clk or posedge reset) begin
                if (reset) begin
                    sync_a[gi] <= 1'b0;
                    sync_b[gi] <= 1'b0;
                end else begin
                    sync_a[gi] <= async_in[gi];
                    sync_b[gi] <= sync_a[gi];
                end
            end
        end
    endgenerate
    // bit positions in the synchroniser word
    localparam SI_BAT_ON = 8;
    localparam SI_BAT_OFF = 7;
    localparam SI_REG_OK = 6;
    localparam SI_REG_LOW = 5;
    localparam SI_THERMAL = 4;
    localparam SI_BUS_LOW = 3;
    localparam SI_TXD = 2;
    localparam SI_CS = 1;
    localparam SI_FAULT_PIN = 0;

    wire s_bat_on = sync_b[SI_BAT_ON];
    wire s_bat_off = sync_b[SI_BAT_OFF];
    wire s_reg_ok = sync_b[SI_REG_OK];
    wire s_reg_low = sync_b[SI_REG_LOW];
    wire s_thermal = sync_b[SI_THERMAL];
    wire s_bus_low = sync_b[SI_BUS_LOW];
    wire s_txd = sync_b[SI_TXD];
    wire s_cs = sync_b[SI_CS];
    wire s_fault_pin = sync_b[SI_FAULT_PIN];

    reg [4:0] state;
    reg [4:0] next_state;
    reg cs_prev;
    reg [CNT_W-1:0] wake_cnt;
    reg bus_wake;
    reg [CNT_W-1:0] settle_cnt;
    reg [CNT_W-1:0] mis_cnt;
    reg mismatch_fault;
    reg reg_cut;

    wire cs_fall = cs_prev & ~s_cs;
    // the synchronised pin echoes our own pull-down, so it also covers internal faults
    wire internal_fault = s_thermal | mismatch_fault | ~s_reg_ok | reg_cut;
    wire settled = s_reg_ok && (settle_cnt == {CNT_W{1'b0}});

    // wake filter: a low pulse shorter than the full time restarts the count
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            wake_cnt <= {CNT_W{1'b0}};
            bus_wake <= 1'b0;
        end else if (!s_bus_low || state != ST_PDOWN) begin
            wake_cnt <= {CNT_W{1'b0}};
            bus_wake <= 1'b0;
        end else if (wake_cnt >= WAKE_CYC - 1'b1) begin
            bus_wake <= 1'b1;
        end else begin
            wake_cnt <= wake_cnt + 1'b1;
        end
    end

    // regulator settle timer, bounds the wait after a wake
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            settle_cnt <= SETTLE_CYC;
        end else if (!regulator_enable || !s_reg_ok) begin
            settle_cnt <= SETTLE_CYC;
        end else if (settle_cnt != {CNT_W{1'b0}}) begin
            settle_cnt <= settle_cnt - 1'b1;
        end
    end

    // mismatch debounce covers the bus loop delay
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            mis_cnt <= {CNT_W{1'b0}};
            mismatch_fault <= 1'b0;
        end else if ((state != ST_OPER && state != ST_TXOFF) || (s_txd == ~s_bus_low)) begin
            // held while contention lasts, else the fault would chatter
            mis_cnt <= {CNT_W{1'b0}};
            mismatch_fault <= 1'b0;
        end else if (mis_cnt >= MISMATCH_CYC - 1'b1) begin
            mismatch_fault <= 1'b1;
        end else begin
            mis_cnt <= mis_cnt + 1'b1;
        end
    end

    // regulator cut-off latch, cleared only by a fresh power-on
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            reg_cut <= 1'b0;
        end else if (state == ST_POR) begin
            reg_cut <= 1'b0;
        end else if (regulator_enable && s_reg_low && settled) begin
            reg_cut <= 1'b1;
        end
    end

    always @* begin
        next_state = state;
        case (state)
            ST_POR: begin
                if (s_bat_on && !s_bat_off) begin
                    next_state = s_cs ? ST_OPER : ST_READY;
                end
            end
            ST_READY: begin
                // own fault pull must be released first, else operation bounces
                if (s_reg_ok && s_cs && s_fault_pin) begin
                    next_state = ST_OPER;
                end
            end
            ST_OPER: begin
                if (cs_fall) begin
                    next_state = ST_PDOWN;
                end else if (!s_fault_pin) begin
                    next_state = ST_TXOFF;
                end
            end
            ST_TXOFF: begin
                if (!s_cs) begin
                    next_state = ST_PDOWN;
                end else if (s_fault_pin) begin
                    next_state = ST_OPER;
                end
            end
            ST_PDOWN: begin
                if (bus_wake || s_cs) begin
                    next_state = ST_READY;
                end
            end
            default: begin
                next_state = ST_POR;
            end
        endcase
        if (s_bat_off) begin
            next_state = ST_POR;
        end
    end

    // ready after a wake moves on by itself once settled
    reg cs_prev_wake;
    reg [4:0] goto_state;
    always @* begin
        goto_state = next_state;
        // a bus wake has no chip select to wait for, only the regulator
        if (state == ST_READY && settled && cs_prev_wake) begin
            goto_state = ST_OPER;
        end
    end

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            state <= ST_POR;
            cs_prev <= 1'b0;
        end else begin
            state <= s_bat_off ? ST_POR : goto_state;
            cs_prev <= s_cs;
        end
    end

    // remembers that ready was entered by a wake
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            cs_prev_wake <= 1'b0;
        end else begin
            if (state == ST_PDOWN && next_state == ST_READY) begin
                cs_prev_wake <= 1'b1;
            end else if (state != ST_READY) begin
                cs_prev_wake <= 1'b0;
            end
        end
    end

    // next values of the registered outputs
    reg next_regulator_enable;
    reg next_driver_enable;
    reg next_wake_detect_enable;
    reg next_bus_line_drive_low;
    reg next_fault_pin_oe_n;
    wire reg_run = !s_thermal && !reg_cut;
    wire tx_allowed = s_fault_pin && !internal_fault;
    always @* begin
        next_regulator_enable = 1'b0;
        next_driver_enable = 1'b0;
        next_wake_detect_enable = 1'b0;
        next_bus_line_drive_low = 1'b0;
        next_fault_pin_oe_n = 1'b1;
        case (state)
            ST_READY: begin
                next_regulator_enable = reg_run;
                next_wake_detect_enable = 1'b1;
                next_fault_pin_oe_n = !internal_fault;
            end
            ST_OPER: begin
                next_regulator_enable = reg_run;
                next_driver_enable = tx_allowed;
                next_bus_line_drive_low = tx_allowed && !s_txd;
                next_fault_pin_oe_n = !internal_fault;
            end
            ST_TXOFF: begin
                next_regulator_enable = reg_run;
                next_fault_pin_oe_n = !internal_fault;
            end
            ST_PDOWN: begin
                // regulator down reads as a fault, so the pin stays low
                next_wake_detect_enable = 1'b1;
                next_fault_pin_oe_n = !internal_fault;
            end
            default: begin
                next_fault_pin_oe_n = 1'b1;
            end
        endcase
    end

    // registered outputs
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            driver_enable <= 1'b0;
            regulator_enable <= 1'b0;
            wake_detect_enable <= 1'b0;
            bus_line_drive_low <= 1'b0;
            rx_data <= 1'b1;
            fault_tx_enable_pin_out <= 1'b0;
            fault_tx_enable_pin_oe_n <= 1'b1;
            mode <= ST_POR;
        end else begin
            mode <= state;
            regulator_enable <= next_regulator_enable;
            wake_detect_enable <= next_wake_detect_enable;
            driver_enable <= next_driver_enable;
            bus_line_drive_low <= next_bus_line_drive_low;
            rx_data <= ~s_bus_low;
            fault_tx_enable_pin_out <= 1'b0;
            // pin pulled low while a fault stands, except in power-on reset; active-low enable
            fault_tx_enable_pin_oe_n <= next_fault_pin_oe_n;
        end
    end
endmodule

// file: tb/lmc_mode_checker.sv
`timescale 1ns/10ps
`include "lmc_regs.vh"
module lmc_mode_checker (
    // clock and reset
    input wire clk,
    input wire reset,
    // watched inputs
    input wire battery_off,
    input wire thermal_overload,
    input wire bus_line_low,
    input wire tx_data,
    input wire fault_tx_enable_pin_in,
    // watched outputs
    input wire rx_data,
    input wire bus_line_drive_low,
    input wire driver_enable,
    input wire regulator_enable,
    input wire [4:0] mode
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // outputs trail the state by an edge, so dwell two cycles first
    sequence s_in(m); (mode == m) [*2]; endsequence
    sequence s_tx_held; (driver_enable && $stable(tx_data)) [*6]; endsequence
    property p_off; battery_off [*6] |-> mode == `LMC_ST_POR; endproperty
    a_off: assert property (p_off) else $error("no return to reset");
    property p_pd; s_in(`LMC_ST_PDOWN) |-> !driver_enable && !regulator_enable; endproperty
    a_pd: assert property (p_pd) else $error("power-down not off");
    property p_rdy; s_in(`LMC_ST_READY) |-> regulator_enable && !driver_enable; endproperty
    a_rdy: assert property (p_rdy) else $error("ready outputs wrong");
    property p_entry;
        $rose(mode == `LMC_ST_PDOWN) |-> $past(mode) inside {`LMC_ST_OPER, `LMC_ST_TXOFF};
    endproperty
    a_entry: assert property (p_entry) else $error("bad power-down entry");
    property p_pin; !fault_tx_enable_pin_in [*6] |-> !driver_enable; endproperty
    a_pin: assert property (p_pin) else $error("driver on with pin low");
    property p_hot; thermal_overload [*6] |-> !driver_enable && !regulator_enable; endproperty
    a_hot: assert property (p_hot) else $error("no thermal shutdown");
    property p_rx; $stable(bus_line_low) [*6] |-> rx_data == !bus_line_low; endproperty
    a_rx: assert property (p_rx) else $error("rx not following bus");
    property p_drv; s_tx_held |-> bus_line_drive_low == !tx_data; endproperty
    a_drv: assert property (p_drv) else $error("bus drive not following tx");
endmodule

// file: tb/lmc_host_model.sv
`timescale 1ns/10ps
module lmc_host_model (
    // clock and bench requests
    input wire clk,
    input wire cs_req,
    input wire tx_req,
    input wire pull_req,
    // device pins
    input wire fault_tx_enable_pin_oe_n,
    output reg chip_select_wake,
    output reg tx_data,
    output wire fault_tx_enable_pin_in
);
    initial chip_select_wake = 1'h0;
    initial tx_data = 1'h1;
    always @(posedge clk) begin
        chip_select_wake <= cs_req;
        tx_data <= tx_req;
    end
    // pulled-up wire: low when either side sinks it
    assign fault_tx_enable_pin_in = ~(pull_req | ~fault_tx_enable_pin_oe_n);
endmodule

// file: tb/testbench.sv
`timescale 1ns/10ps
`include "lmc_regs.vh"
module testbench;
    reg clk = 1'h0, reset = 1'h1, battery_on = 1'h0, battery_off = 1'h0, regulator_ok = 1'h0;
    reg thermal_overload = 1'h0, ext_low = 1'h0, cs_req = 1'h0, tx_req = 1'h1, pull_req = 1'h0;
    reg [7:0] lfsr = 8'h39;
    reg [4:0] last_mode = 5'h01;
    reg [4:0] exp_q[$];
    integer fail_count = 0, num_checks = 0, i;
    wire cs, txd, pin_in, oe_n, rxd, drive_low, drv_en, reg_en;
    wire [4:0] mode;
    // other nodes may hold the bus low as well
    wire bus_line_low = drive_low | ext_low;
    always #25 clk = ~clk;
    always @(posedge clk) regulator_ok <= reg_en;
    lmc_host_model i_lmc_host_model (.clk(clk), .cs_req(cs_req), .tx_req(tx_req),
        .pull_req(pull_req), .fault_tx_enable_pin_oe_n(oe_n), .chip_select_wake(cs),
        .tx_data(txd), .fault_tx_enable_pin_in(pin_in));
    lmc_mode_control #(.WAKE_CYC(16'h6), .SETTLE_CYC(16'h10), .MISMATCH_CYC(16'h10))
    i_lmc_mode_control (.clk(clk), .reset(reset), .battery_on(battery_on),
        .battery_off(battery_off), .regulator_ok(regulator_ok), .regulator_low(1'h0),
        .thermal_overload(thermal_overload), .bus_line_low(bus_line_low), .tx_data(txd),
        .chip_select_wake(cs), .fault_tx_enable_pin_in(pin_in), .fault_tx_enable_pin_out(),
        .fault_tx_enable_pin_oe_n(oe_n), .rx_data(rxd), .bus_line_drive_low(drive_low),
        .driver_enable(drv_en), .regulator_enable(reg_en), .wake_detect_enable(),
        .mode(mode));
    function [7:0] next_lfsr(input [7:0] v);
        next_lfsr = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task check(input [4:0] seen, input [4:0] want);
        begin
            num_checks = num_checks + 1;
            if (seen !== want) begin
                fail_count = fail_count + 1;
                $display("FAIL %0t seen %h expected %h", $time, seen, want);
            end
        end
    endtask
    task summarize;
        begin
            $display("checks %0d mismatches %0d", num_checks, fail_count);
            if (fail_count == 0 && num_checks > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    // note the next mode, then wait for it under a bound
    task move(input [4:0] m);
        integer n;
        begin
            exp_q.push_back(m);
            for (n = 0; n < 300 && (mode !== m || exp_q.size() != 0); n = n + 1)
                @(negedge clk);
            if (mode !== m || exp_q.size() != 0) begin
                fail_count = fail_count + 1;
                summarize;
            end
        end
    endtask
    // every mode change must be the oldest noted one
    always @(negedge clk) begin
        if (!reset && mode !== last_mode) begin
            check(mode, exp_q.size() > 0 ? exp_q.pop_front() : last_mode);
            last_mode = mode;
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        reset <= 1'h0;
        battery_on <= 1'h1;
        move(`LMC_ST_READY);
        @(posedge clk) cs_req <= 1'h1;
        move(`LMC_ST_OPER);
        for (i = 0; i < 80; i = i + 1) begin
            @(posedge clk);
            if (i % 8 == 0)
                tx_req <= lfsr[0];
            lfsr <= next_lfsr(lfsr);
            @(negedge clk);
            if (i % 8 == 7)
                check({4'h0, rxd}, {4'h0, tx_req});
        end
        @(posedge clk) tx_req <= 1'h1;
        ext_low <= 1'h1;
        move(`LMC_ST_TXOFF);
        check({4'h0, rxd}, 5'h00);
        @(posedge clk) cs_req <= 1'h0;
        ext_low <= 1'h0;
        move(`LMC_ST_PDOWN);
        @(posedge clk) ext_low <= 1'h1;
        repeat (2) @(posedge clk);
        ext_low <= 1'h0;
        repeat (20) @(posedge clk);
        ext_low <= 1'h1;
        move(`LMC_ST_READY);
        @(posedge clk) ext_low <= 1'h0;
        move(`LMC_ST_OPER);
        @(posedge clk) cs_req <= 1'h1;
        pull_req <= 1'h1;
        move(`LMC_ST_TXOFF);
        @(posedge clk) pull_req <= 1'h0;
        move(`LMC_ST_OPER);
        @(posedge clk) cs_req <= 1'h0;
        move(`LMC_ST_PDOWN);
        @(posedge clk) cs_req <= 1'h1;
        move(`LMC_ST_READY);
        move(`LMC_ST_OPER);
        @(posedge clk) thermal_overload <= 1'h1;
        move(`LMC_ST_TXOFF);
        @(posedge clk) battery_off <= 1'h1;
        battery_on <= 1'h0;
        move(`LMC_ST_POR);
        @(posedge clk) battery_off <= 1'h0;
        thermal_overload <= 1'h0;
        battery_on <= 1'h1;
        // regulator still starting: operation drops to transmitter-off once
        exp_q.push_back(`LMC_ST_OPER);
        exp_q.push_back(`LMC_ST_TXOFF);
        move(`LMC_ST_OPER);
        repeat (4) @(posedge clk);
        summarize;
    end
endmodule
bind lmc_mode_control lmc_mode_checker i_lmc_mode_checker (.clk(clk), .reset(reset),
    .battery_off(battery_off), .thermal_overload(thermal_overload),
    .bus_line_low(bus_line_low), .tx_data(tx_data),
    .fault_tx_enable_pin_in(fault_tx_enable_pin_in), .rx_data(rx_data),
    .bus_line_drive_low(bus_line_drive_low), .driver_enable(driver_enable),
    .regulator_enable(regulator_enable), .mode(mode));
